// File: hv_pin_and_supply_irq_regs.sv
// How it works
// - Bank 0 fail status: pin 4..1 short flags on bits 7,5,3,1.
// - Bank 0 fail status: pin 4..1 open-load flags on bits 6,4,2,0.
// - Bank 1 wake status: pin 8..5 falling-edge flags on bits 7,5,3,1.
// - Bank 1 wake status: pin 8..5 rising-edge flags on bits 6,4,2,0.
// - Bank 1 fail status: pin 8..5 short flags on bits 7,5,3,1.
// - Bank 1 fail status: pin 8..5 open-load flags on bits 6,4,2,0.
// - System enable: overtemp warning bit 2, serial failure bit 1, rest read-only zero.
// - Supply enable: converter change bit 5, battery over 4, under 3; 7:6 reserved.
// - Supply enable: sensor supply over bit 2, under bit 1, main regulator under bit 0.
// - Converter status flag sets whenever the converter status bit changes.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "hv_irq_consts.svh"

module hv_pin_and_supply_irq_regs
	import hv_irq_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire bank_fault_t bank0_fault,
	input wire bank_fault_t bank1_fault,
	input wire logic [3:0] high_voltage_pin,
	input wire system_evt_t system_evt,
	input wire supply_evt_t supply_evt,
	input wire logic converter_status_bit,
	output logic irq
);

	// ----------------------------------------
	// Bus address phase capture
	// ----------------------------------------
	logic req;
	logic accept;
	logic stall;
	logic [7:0] req_index;
	logic req_mapped;
	bus_phase_t phase_reg;
	logic wr_pending_reg;
	logic wr_en;
	logic [7:0] wr_byte;

	assign req = hsel & htrans[1];
	assign req_index = haddr[9:2];
	assign req_mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);

	// A read right behind a write waits one cycle so it sees the written value.
	assign stall = req & ~hwrite & wr_pending_reg;
	assign hreadyout = ~stall;
	assign hresp = 1'b0;
	assign accept = req & hready & ~stall;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase_reg <= '0;
			wr_pending_reg <= 1'b0;
		end
		else
		begin
			wr_pending_reg <= accept & hwrite;
			if (accept)
			begin
				phase_reg.write <= hwrite;
				phase_reg.index <= req_index;
				phase_reg.mapped <= req_mapped;
			end
		end
	end

	// Only the low byte of a word carries register bits; hsize is not checked.
	assign wr_en = wr_pending_reg & phase_reg.mapped;
	assign wr_byte = hwdata[7:0];

	// ----------------------------------------
	// Enable registers
	// ----------------------------------------
	logic [7:0] sys_en_reg;
	logic [7:0] sup_en_reg;
	logic [7:0] b0_fail_en_reg;
	logic [7:0] b1_wake_en_reg;
	logic [7:0] b1_fail_en_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sys_en_reg <= `HV_RESET_BYTE;
			sup_en_reg <= `HV_RESET_BYTE;
			b0_fail_en_reg <= `HV_RESET_BYTE;
			b1_wake_en_reg <= `HV_RESET_BYTE;
			b1_fail_en_reg <= `HV_RESET_BYTE;
		end
		else if (wr_en)
		begin
			unique case (phase_reg.index)
				`HV_IDX_SYS_EN: sys_en_reg <= wr_byte & `HV_SYS_MASK;
				`HV_IDX_SUP_EN: sup_en_reg <= wr_byte & `HV_SUP_MASK;
				`HV_IDX_B0_FAIL_EN: b0_fail_en_reg <= wr_byte;
				`HV_IDX_B1_WAKE_EN: b1_wake_en_reg <= wr_byte;
				`HV_IDX_B1_FAIL_EN: b1_fail_en_reg <= wr_byte;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Edge detection on pins and converter status
	// ----------------------------------------
	// The first sample after reset only primes the history, so a pin that
	// is already high at release does not fake a rising edge.
	logic primed_reg;
	logic [3:0] pin_prev_reg;
	logic conv_prev_reg;
	logic [3:0] pin_rise;
	logic [3:0] pin_fall;
	logic conv_change;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			primed_reg <= 1'b0;
			pin_prev_reg <= 4'h0;
			conv_prev_reg <= 1'b0;
		end
		else
		begin
			primed_reg <= 1'b1;
			pin_prev_reg <= high_voltage_pin;
			conv_prev_reg <= converter_status_bit;
		end
	end

	assign pin_rise = primed_reg ? (high_voltage_pin & ~pin_prev_reg) : 4'h0;
	assign pin_fall = primed_reg ? (~high_voltage_pin & pin_prev_reg) : 4'h0;
	assign conv_change = primed_reg & (converter_status_bit ^ conv_prev_reg);

	// ----------------------------------------
	// Status set vectors
	// ----------------------------------------
	logic [7:0] b0_fail_set;
	logic [7:0] b1_wake_set;
	logic [7:0] b1_fail_set;
	logic [7:0] sys_set;
	logic [7:0] sup_set;

	generate
		for (genvar k = 0; k < 4; k++)
		begin : g_pin
			assign b0_fail_set[2*k+1] = bank0_fault.short_evt[k];
			assign b0_fail_set[2*k] = bank0_fault.openload_evt[k];
			assign b1_wake_set[2*k+1] = pin_fall[k];
			assign b1_wake_set[2*k] = pin_rise[k];
			assign b1_fail_set[2*k+1] = bank1_fault.short_evt[k];
			assign b1_fail_set[2*k] = bank1_fault.openload_evt[k];
		end
	endgenerate

	always_comb
	begin
		sys_set = 8'h00;
		sys_set[`HV_SYS_OTW_BIT] = system_evt.overtemp_warn;
		sys_set[`HV_SYS_SERFAIL_BIT] = system_evt.serial_fail;
		sup_set = 8'h00;
		sup_set[`HV_SUP_CONV_BIT] = conv_change;
		sup_set[`HV_SUP_BATO_BIT] = supply_evt.battery_over;
		sup_set[`HV_SUP_BATU_BIT] = supply_evt.battery_under;
		sup_set[`HV_SUP_SENSO_BIT] = supply_evt.sensor_supply_over;
		sup_set[`HV_SUP_SENSU_BIT] = supply_evt.sensor_supply_under;
		sup_set[`HV_SUP_MAINU_BIT] = supply_evt.main_reg_under;
	end

	// ----------------------------------------
	// Sticky status banks
	// ----------------------------------------
	logic [7:0] b0_fail_st;
	logic [7:0] b1_wake_st;
	logic [7:0] b1_fail_st;
	logic [7:0] sys_st;
	logic [7:0] sup_st;

	irq_status_bank #(.WIDTH(8)) u_b0_fail
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.set(b0_fail_set),
		.clr_we(wr_en && (phase_reg.index == `HV_IDX_B0_FAIL_ST)),
		.clr_data(wr_byte),
		.status(b0_fail_st)
	);

	irq_status_bank #(.WIDTH(8)) u_b1_wake
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.set(b1_wake_set),
		.clr_we(wr_en && (phase_reg.index == `HV_IDX_B1_WAKE_ST)),
		.clr_data(wr_byte),
		.status(b1_wake_st)
	);

	irq_status_bank #(.WIDTH(8)) u_b1_fail
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.set(b1_fail_set),
		.clr_we(wr_en && (phase_reg.index == `HV_IDX_B1_FAIL_ST)),
		.clr_data(wr_byte),
		.status(b1_fail_st)
	);

	irq_status_bank #(.WIDTH(8)) u_sys
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.set(sys_set),
		.clr_we(wr_en && (phase_reg.index == `HV_IDX_SYS_ST)),
		.clr_data(wr_byte),
		.status(sys_st)
	);

	irq_status_bank #(.WIDTH(8)) u_sup
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.set(sup_set),
		.clr_we(wr_en && (phase_reg.index == `HV_IDX_SUP_ST)),
		.clr_data(wr_byte),
		.status(sup_st)
	);

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	// Flags keep collecting while disabled, so enabling later raises at once.
	assign irq = |(sys_st & sys_en_reg) | |(sup_st & sup_en_reg) | |(b0_fail_st & b0_fail_en_reg)
		| |(b1_wake_st & b1_wake_en_reg) | |(b1_fail_st & b1_fail_en_reg);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [7:0] rd_byte;
	logic [31:0] hrdata_reg;

	always_comb
	begin
		rd_byte = 8'h00;
		if (req_mapped)
		begin
			unique case (req_index)
				`HV_IDX_SYS_EN: rd_byte = sys_en_reg;
				`HV_IDX_SUP_EN: rd_byte = sup_en_reg;
				`HV_IDX_SYS_ST: rd_byte = sys_st;
				`HV_IDX_SUP_ST: rd_byte = sup_st;
				`HV_IDX_B0_FAIL_ST: rd_byte = b0_fail_st;
				`HV_IDX_B1_WAKE_ST: rd_byte = b1_wake_st;
				`HV_IDX_B1_FAIL_ST: rd_byte = b1_fail_st;
				`HV_IDX_B0_FAIL_EN: rd_byte = b0_fail_en_reg;
				`HV_IDX_B1_WAKE_EN: rd_byte = b1_wake_en_reg;
				`HV_IDX_B1_FAIL_EN: rd_byte = b1_fail_en_reg;
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// Status is sampled at the address phase; an event one cycle later
	// shows on the next read rather than this one.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata_reg <= `HV_RESET_WORD;
		end
		else if (accept && !hwrite)
		begin
			hrdata_reg <= {24'h000000, rd_byte};
		end
	end

	assign hrdata = hrdata_reg;

endmodule : hv_pin_and_supply_irq_regs

`default_nettype wire

// File: hv_irq_consts.svh
`ifndef HV_IRQ_CONSTS_SVH
`define HV_IRQ_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define HV_IDX_SYS_EN 8'h04
`define HV_IDX_SUP_EN 8'h1c
`define HV_IDX_SYS_ST 8'h61
`define HV_IDX_SUP_ST 8'h62
`define HV_IDX_B0_FAIL_ST 8'h65
`define HV_IDX_B1_WAKE_ST 8'h66
`define HV_IDX_B1_FAIL_ST 8'h67
`define HV_IDX_B0_FAIL_EN 8'h38
`define HV_IDX_B1_WAKE_EN 8'h47
`define HV_IDX_B1_FAIL_EN 8'h48

// ----------------------------------------
// Field positions and writable masks
// ----------------------------------------
`define HV_SYS_OTW_BIT 2
`define HV_SYS_SERFAIL_BIT 1
`define HV_SYS_MASK 8'h06
`define HV_SUP_CONV_BIT 5
`define HV_SUP_BATO_BIT 4
`define HV_SUP_BATU_BIT 3
`define HV_SUP_SENSO_BIT 2
`define HV_SUP_SENSU_BIT 1
`define HV_SUP_MAINU_BIT 0
`define HV_SUP_MASK 8'h3f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HV_RESET_BYTE 8'h00
`define HV_RESET_WORD 32'h0000_0000

`endif

// File: hv_irq_pkg.sv
package hv_irq_pkg;

	// ----------------------------------------
	// Event carriers
	// ----------------------------------------
	// Index 0 is pin 1 (bank 0) or pin 5 (bank 1), index 3 is pin 4 or pin 8.
	typedef struct packed {
		logic [3:0] short_evt;
		logic [3:0] openload_evt;
	} bank_fault_t;

	typedef struct packed {
		logic overtemp_warn;
		logic serial_fail;
	} system_evt_t;

	typedef struct packed {
		logic battery_over;
		logic battery_under;
		logic sensor_supply_over;
		logic sensor_supply_under;
		logic main_reg_under;
	} supply_evt_t;

	typedef struct packed {
		logic write;
		logic [7:0] index;
		logic mapped;
	} bus_phase_t;

endpackage : hv_irq_pkg

// File: irq_status_bank.sv
`timescale 1ns/1ps
`default_nettype none

module irq_status_bank
#(
	parameter int WIDTH = 8
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [WIDTH-1:0] set,
	input wire logic clr_we,
	input wire logic [WIDTH-1:0] clr_data,
	output logic [WIDTH-1:0] status
);

	logic [WIDTH-1:0] status_reg;
	logic [WIDTH-1:0] status_next;

	// A set in the same cycle as a clear wins, so no event is lost.
	always_comb
	begin
		status_next = status_reg;
		if (clr_we)
		begin
			status_next = status_next & ~clr_data;
		end
		status_next = status_next | set;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status_reg <= '0;
		end
		else
		begin
			status_reg <= status_next;
		end
	end

	assign status = status_reg;

endmodule : irq_status_bank

`default_nettype wire

// File: ahb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Bus host
// ----------------
module ahb_host_model
(
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	output logic hang
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hang = 1'b0;
	end
	// Entered just after a rising edge; each phase is held until hready is seen high.
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 64);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 64);
		q = hrdata;
		if (n >= 64)
			hang = 1'b1;
	endtask : xfer
endmodule : ahb_host_model
`default_nettype wire

// File: hv_irq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Port checks
// ----------------
module hv_irq_asserts
	import hv_irq_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire bank_fault_t bank0_fault,
	input wire bank_fault_t bank1_fault,
	input wire logic [3:0] high_voltage_pin,
	input wire system_evt_t system_evt,
	input wire supply_evt_t supply_evt,
	input wire logic converter_status_bit,
	input wire logic irq
);
	logic tk;
	logic wc;
	logic [7:0] p0_reg;
	logic [7:0] p1_reg;
	logic [7:0] pw_reg;
	logic [3:0] pv_reg;
	logic pc_reg;
	logic cv_reg;
	logic armed_reg;
	assign tk = hsel && htrans[1] && hready && hreadyout;
	assign wc = tk && hwrite;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Any write drops the expectations, so a flag the host may have cleared is never demanded.
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			p0_reg <= 8'h00;
			p1_reg <= 8'h00;
			pw_reg <= 8'h00;
			pv_reg <= 4'h0;
			pc_reg <= 1'b0;
			cv_reg <= 1'b0;
			armed_reg <= 1'b0;
		end
		else
		begin
			armed_reg <= 1'b1;
			pv_reg <= high_voltage_pin;
			cv_reg <= converter_status_bit;
			pc_reg <= !wc && (pc_reg || armed_reg && cv_reg != converter_status_bit);
			for (int i = 0; i < 4; i++)
			begin
				p0_reg[2*i+1] <= !wc && (p0_reg[2*i+1] || bank0_fault.short_evt[i]);
				p0_reg[2*i] <= !wc && (p0_reg[2*i] || bank0_fault.openload_evt[i]);
				p1_reg[2*i+1] <= !wc && (p1_reg[2*i+1] || bank1_fault.short_evt[i]);
				p1_reg[2*i] <= !wc && (p1_reg[2*i] || bank1_fault.openload_evt[i]);
				pw_reg[2*i+1] <= !wc && (pw_reg[2*i+1] || armed_reg && pv_reg[i] && !high_voltage_pin[i]);
				pw_reg[2*i] <= !wc && (pw_reg[2*i] || armed_reg && !pv_reg[i] && high_voltage_pin[i]);
			end
		end
	a_bank0_fail_flags: assert property (tk && !hwrite && haddr == 32'h194 |=>
		(hrdata[7:0] & $past(p0_reg)) == $past(p0_reg)) else $error("bank 0 fail flag lost");
	a_bank1_fail_flags: assert property (tk && !hwrite && haddr == 32'h19c |=>
		(hrdata[7:0] & $past(p1_reg)) == $past(p1_reg)) else $error("bank 1 fail flag lost");
	a_bank1_wake_flags: assert property (tk && !hwrite && haddr == 32'h198 |=>
		(hrdata[7:0] & $past(pw_reg)) == $past(pw_reg)) else $error("wake edge flag lost");
	a_conv_change_flag: assert property (tk && !hwrite && haddr == 32'h188 |=>
		hrdata[5] || !$past(pc_reg)) else $error("converter change flag lost");
	a_sys_reserved_zero: assert property (tk && !hwrite && haddr == 32'h10 |=>
		(hrdata & 32'hffff_fff9) == 32'h0) else $error("system enable reserved bits set");
	a_sup_reserved_zero: assert property (tk && !hwrite && haddr == 32'h70 |=>
		hrdata[31:6] == 26'h0) else $error("supply enable reserved bits set");
	a_irq_has_cause: assert property ($rose(irq) |-> $past(|{bank0_fault, bank1_fault, system_evt, supply_evt})
		|| $past(high_voltage_pin) != $past(high_voltage_pin, 2) || $past(wc, 2)
		|| $past(converter_status_bit) != $past(converter_status_bit, 2)) else $error("irq rose without cause");
	a_irq_drop_write: assert property ($fell(irq) |-> $past(wc, 2)) else $error("irq fell without write");
	a_resp_always_okay: assert property (tk |=> !hresp) else $error("error response on a transfer");
endmodule : hv_irq_asserts
bind hv_pin_and_supply_irq_regs hv_irq_asserts chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hreadyout, .hrdata, .hresp, .bank0_fault, .bank1_fault, .high_voltage_pin, .system_evt,
	.supply_evt, .converter_status_bit, .irq);
`default_nettype wire

// File: hv_pin_and_supply_irq_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Bench
// ----------------
module hv_pin_and_supply_irq_regs_tb
	import hv_irq_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic irq;
	bank_fault_t b0;
	bank_fault_t b1;
	logic [3:0] pins;
	system_evt_t sy;
	supply_evt_t su;
	logic conv;
	int mismatches = 0;
	int checks_done = 0;
	always #10 hclk = ~hclk;
	ahb_host_model host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang());
	hv_pin_and_supply_irq_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bank0_fault(b0), .bank1_fault(b1),
		.high_voltage_pin(pins), .system_evt(sy), .supply_evt(su), .converter_status_bit(conv), .irq(irq));
	task automatic end_of_test();
		if (host_u.hang === 1'b1)
		begin
			mismatches++;
			$display("mismatch at %0t: bus wait timed out", $time);
		end
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		host_u.xfer(1'b1, idx, d, q);
		if (host_u.hang === 1'b1)
			end_of_test();
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] q;
		host_u.xfer(1'b0, idx, 8'h00, q);
		if (host_u.hang === 1'b1)
			end_of_test();
		chk(q[7:0], exp);
	endtask : rd
	task automatic irq_is(input logic exp);
		@(negedge hclk);
		chk({7'h0, irq}, {7'h0, exp});
		@(posedge hclk);
	endtask : irq_is
	task automatic s_reset();
		rd(8'h04, 8'h00);
		rd(8'h1c, 8'h00);
		rd(8'h65, 8'h00);
		rd(8'h66, 8'h00);
		rd(8'h67, 8'h00);
		rd(8'h05, 8'h00);
	endtask : s_reset
	task automatic s_enables();
		wr(8'h04, 8'hff);
		rd(8'h04, 8'h06);
		wr(8'h1c, 8'hc7);
		rd(8'h1c, 8'h07);
		wr(8'h1c, 8'hf8);
		rd(8'h1c, 8'h38);
	endtask : s_enables
	task automatic s_faults();
		logic [7:0] e;
		for (int k = 0; k < 8; k++)
		begin
			b0 <= 8'h01 << k;
			b1 <= 8'h01 << k;
			@(posedge hclk);
			b0 <= 8'h00;
			b1 <= 8'h00;
			e = k < 4 ? 8'h01 << (2 * k) : 8'h01 << (2 * k - 7);
			rd(8'h65, e);
			rd(8'h67, e);
			wr(8'h65, 8'h00);
			rd(8'h65, e);
			wr(8'h65, e);
			wr(8'h67, e);
			rd(8'h65, 8'h00);
			rd(8'h67, 8'h00);
		end
	endtask : s_faults
	task automatic s_wake();
		for (int k = 0; k < 4; k++)
		begin
			pins <= 4'h1 << k;
			@(posedge hclk);
			rd(8'h66, 8'h01 << (2 * k));
			pins <= 4'h0;
			@(posedge hclk);
			rd(8'h66, 8'h03 << (2 * k));
			irq_is(1'b0);
			wr(8'h66, 8'hff);
		end
	endtask : s_wake
	task automatic s_irq();
		b0 <= 8'h10;
		@(posedge hclk);
		b0 <= 8'h00;
		irq_is(1'b0);
		wr(8'h38, 8'h02);
		irq_is(1'b1);
		wr(8'h65, 8'h00);
		irq_is(1'b1);
		wr(8'h65, 8'h02);
		irq_is(1'b0);
		conv <= 1'b1;
		@(posedge hclk);
		irq_is(1'b1);
		rd(8'h62, 8'h20);
		wr(8'h62, 8'h20);
		irq_is(1'b0);
		sy <= 2'b10;
		@(posedge hclk);
		sy <= 2'b00;
		irq_is(1'b1);
		wr(8'h61, 8'h04);
		irq_is(1'b0);
	endtask : s_irq
	// Supply sources, serial failure, bank 1 fail and wake enables each gate the line.
	task automatic s_supply();
		for (int i = 0; i < 5; i++)
		begin
			su <= 5'h01 << i;
			@(posedge hclk);
			su <= 5'h00;
			rd(8'h62, 8'h01 << i);
			irq_is(i >= 3);
			wr(8'h62, 8'h01 << i);
			irq_is(1'b0);
		end
		su <= 5'h01;
		@(posedge hclk);
		su <= 5'h00;
		irq_is(1'b0);
		wr(8'h1c, 8'h01);
		irq_is(1'b1);
		wr(8'h62, 8'h01);
		irq_is(1'b0);
		sy <= 2'b01;
		@(posedge hclk);
		sy <= 2'b00;
		irq_is(1'b1);
		wr(8'h04, 8'h04);
		irq_is(1'b0);
		rd(8'h61, 8'h02);
		wr(8'h61, 8'h02);
		b1 <= 8'h80;
		@(posedge hclk);
		b1 <= 8'h00;
		irq_is(1'b0);
		wr(8'h48, 8'h80);
		irq_is(1'b1);
		wr(8'h67, 8'h80);
		irq_is(1'b0);
		wr(8'h47, 8'h01);
		pins <= 4'h1;
		@(posedge hclk);
		irq_is(1'b1);
		wr(8'h66, 8'h01);
		irq_is(1'b0);
		pins <= 4'h0;
		@(posedge hclk);
		irq_is(1'b0);
		rd(8'h66, 8'h02);
		wr(8'h66, 8'h02);
	endtask : s_supply
	initial
	begin
		b0 = 8'h00;
		b1 = 8'h00;
		pins = 4'h0;
		sy = 2'h0;
		su = 5'h00;
		conv = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		s_reset();
		s_enables();
		s_faults();
		s_wake();
		s_irq();
		s_supply();
		end_of_test();
	end
endmodule : hv_pin_and_supply_irq_regs_tb
`default_nettype wire
